// File: src/boid_params.svh
`ifndef BOID_PARAMS_SVH
`define BOID_PARAMS_SVH
`define BOID_IW 14
`define BOID_DW 8
`define BOID_AW 7
`define BOID_QPHASES 3'h4
`define BOID_Q_LAST 2'h3
`define BOID_Q_READ 2'h1
`define BOID_Q_WRITE 2'h3
`define BOID_CLASS_BYTE 2'h0
`define BOID_CLASS_BIT 2'h1
`define BOID_CLASS_CTL 2'h2
`define BOID_CLASS_LIT 2'h3
`define BOID_OP_ADD 4'h7
`define BOID_OP_AND 4'h5
`define BOID_OP_OR 4'h4
`define BOID_OP_ZERO 4'h1
`define BOID_OP_NOPMOV 4'h0
`define BOID_OP_DECSKP 4'hB
`define BOID_OP_INCSKP 4'hF
`define BOID_OP_RLC 4'hD
`define BOID_OP_RRC 4'hC
`define BOID_NOP_MASK 14'h3F9F
`define BOID_NOP_CODE 14'h0000
`define BOID_NIB 4
`endif

// File: src/boid_pkg.sv
`include "boid_params.svh"
package boid_pkg;
    typedef struct packed {
        logic [1:0] cls;
        logic [3:0] op;
        logic dest;
        logic [6:0] faddr;
        logic [2:0] bsel;
        logic [7:0] lit8;
        logic [10:0] lit11;
    } boid_fields_t;
    typedef struct packed {
        logic c;
        logic dc;
        logic z;
    } boid_flags_t;
    typedef enum logic [1:0] {
        BOID_RUN = 2'b00,
        BOID_FLUSH = 2'b01
    } boid_state_t;
endpackage

// File: src/boid_field_split.sv
`timescale 1ns/1ps
`include "boid_params.svh"
module boid_field_split (
    input wire logic mclk,
    input wire logic reset,
    input wire logic load,
    input wire logic [13:0] word,
    output boid_pkg::boid_fields_t fields
);
    import boid_pkg::*;
    // latches the split instruction word at fetch
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fields <= '0;
        end else if (load) begin
            fields.cls <= word[13:12];
            fields.op <= word[11:8];
            fields.dest <= word[7];
            fields.faddr <= word[6:0];
            fields.bsel <= word[9:7];
            fields.lit8 <= word[7:0];
            fields.lit11 <= word[10:0];
        end
    end
endmodule

// File: src/boid_decoder.sv
`timescale 1ns/1ps
`include "boid_params.svh"
// What this block does
// - instruction is one 14-bit opcode-plus-operands word
// - dest bit 0 to accumulator, 1 to file
// - file address is 7 bits, 0x00-0x7F
// - bit select picks bit of 8-bit file
// - literals are eight or eleven bits wide
// - four clock phases per instruction cycle
// - skip adds one no-op cycle
// - file always read before modify and store
// - zero-file reads, zeroes, writes back register
// - don't-care bits ignored in decoding
// - byte ops: top bits 00, opcode, d, f
// - add, and, or with accumulator; flags
// - decrement, store, skip when zero
// - increment, store, skip when zero
// - rotate left through carry, carry only
// - rotate right through carry, carry only
module boid_decoder (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [13:0] instr_word,
    output logic fetch_stb,
    output logic [6:0] file_addr,
    output logic file_rd_stb,
    input wire logic [7:0] file_rd_data,
    output logic file_wr_stb,
    output logic [7:0] file_wr_data,
    output logic [7:0] acc,
    output boid_pkg::boid_flags_t flags,
    output logic [2:0] bit_sel,
    output logic [10:0] literal,
    output logic executing_nop,
    output logic unsupported
);
    import boid_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // phase counter and fetch
    logic [1:0] q_reg;
    boid_state_t st_reg;
    boid_fields_t fld;
    logic is_last;

    assign is_last = (q_reg == `BOID_Q_LAST);
    assign fetch_stb = is_last;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q_reg <= 2'h0;
        end else begin
            q_reg <= q_reg + 2'h1;
        end
    end

    boid_field_split u_split (
        .mclk(mclk),
        .reset(reset),
        .load(is_last),
        .word(instr_word),
        .fields(fld)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode
    function automatic logic is_byte_op(input boid_fields_t f);
        return f.cls == `BOID_CLASS_BYTE;
    endfunction

    function automatic logic is_nop_word(input boid_fields_t f);
        logic [13:0] w;
        w = {f.cls, f.op, f.lit8};
        return (w & `BOID_NOP_MASK) == `BOID_NOP_CODE;
    endfunction

    logic live;
    logic byte_op;
    logic zero_acc;
    logic known;
    assign live = (st_reg == BOID_RUN);
    assign byte_op = live && is_byte_op(fld);
    // only class bits, op and dest bit matter for zero_accumulator; f bits are don't-care
    assign zero_acc = byte_op && fld.op == `BOID_OP_ZERO && !fld.dest;

    always_comb begin
        known = 1'b0;
        if (byte_op) begin
            case (fld.op)
                `BOID_OP_ADD, `BOID_OP_AND, `BOID_OP_OR, `BOID_OP_ZERO,
                `BOID_OP_DECSKP, `BOID_OP_INCSKP, `BOID_OP_RLC, `BOID_OP_RRC: known = 1'b1;
                `BOID_OP_NOPMOV: known = is_nop_word(fld);
                default: known = 1'b0;
            endcase
        end
    end

    assign executing_nop = !live || (byte_op && fld.op == `BOID_OP_NOPMOV && is_nop_word(fld));
    assign unsupported = live && !known;

    ////////////////////////////////////////////////////////////////////////
    // operand routing
    logic uses_file;
    assign uses_file = byte_op && known && !zero_acc && !(fld.op == `BOID_OP_NOPMOV);
    assign file_addr = fld.faddr;
    assign bit_sel = fld.bsel;
    assign literal = (fld.cls == `BOID_CLASS_CTL) ? fld.lit11 : {3'h0, fld.lit8};
    assign file_rd_stb = uses_file && q_reg == `BOID_Q_READ;

    ////////////////////////////////////////////////////////////////////////
    // operand latch: read data only stands around the read strobe
    logic [7:0] rd_operand_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_operand_reg <= 8'h00;
        end else if (file_rd_stb) begin
            rd_operand_reg <= file_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alu
    logic [7:0] res;
    logic [8:0] sum;
    logic [4:0] nib;
    boid_flags_t fl_next;
    logic skip;

    always_comb begin
        sum = {1'b0, acc} + {1'b0, rd_operand_reg};
        nib = {1'b0, acc[3:0]} + {1'b0, rd_operand_reg[3:0]};
        res = rd_operand_reg;
        fl_next = flags;
        skip = 1'b0;
        case (fld.op)
            `BOID_OP_ADD: begin
                res = sum[7:0];
                fl_next.c = sum[8];
                fl_next.dc = nib[`BOID_NIB];
                fl_next.z = (sum[7:0] == 8'h00);
            end
            `BOID_OP_AND: begin
                res = acc & rd_operand_reg;
                fl_next.z = (res == 8'h00);
            end
            `BOID_OP_OR: begin
                res = acc | rd_operand_reg;
                fl_next.z = (res == 8'h00);
            end
            `BOID_OP_ZERO: begin
                res = 8'h00;
                fl_next.z = 1'b1;
            end
            `BOID_OP_DECSKP: begin
                res = rd_operand_reg - 8'h01;
                skip = (res == 8'h00);
            end
            `BOID_OP_INCSKP: begin
                res = rd_operand_reg + 8'h01;
                skip = (res == 8'h00);
            end
            `BOID_OP_RLC: begin
                res = {rd_operand_reg[6:0], flags.c};
                fl_next.c = rd_operand_reg[7];
            end
            `BOID_OP_RRC: begin
                res = {flags.c, rd_operand_reg[7:1]};
                fl_next.c = rd_operand_reg[0];
            end
            default: begin
                res = rd_operand_reg;
            end
        endcase
    end

    logic write_q;
    assign write_q = q_reg == `BOID_Q_WRITE && (uses_file || zero_acc);
    assign file_wr_stb = write_q && uses_file && fld.dest;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            file_wr_data <= 8'h00;
        end else if (uses_file && q_reg == `BOID_Q_WRITE - 2'h1) begin
            file_wr_data <= res;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            acc <= 8'h00;
        end else if (zero_acc && q_reg == `BOID_Q_WRITE) begin
            acc <= 8'h00;
        end else if (write_q && !fld.dest) begin
            acc <= res;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags <= '0;
        end else if (zero_acc && q_reg == `BOID_Q_WRITE) begin
            flags.z <= 1'b1;
        end else if (write_q) begin
            flags <= fl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // skip flush: next fetched word executes as no-op
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_reg <= BOID_RUN;
        end else if (is_last) begin
            case (st_reg)
                BOID_RUN: st_reg <= (byte_op && skip) ? BOID_FLUSH : BOID_RUN;
                BOID_FLUSH: st_reg <= BOID_RUN;
                default: st_reg <= BOID_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_phase_wrap: assert property (@(posedge mclk) disable iff (reset)
        is_last |=> q_reg == 2'h0 ##3 is_last)
        else $error("phase counter not four long");

    chk_read_before_write: assert property (@(posedge mclk) disable iff (reset)
        file_wr_stb |-> $past(file_rd_stb, 2))
        else $error("file written without read");

    chk_dest_acc: assert property (@(posedge mclk) disable iff (reset)
        file_wr_stb |-> fld.dest)
        else $error("file written with dest zero");

    chk_zero_write: assert property (@(posedge mclk) disable iff (reset)
        (file_wr_stb && fld.op == `BOID_OP_ZERO) |-> file_wr_data == 8'h00)
        else $error("zero-file wrote nonzero");

    sequence s_skip_taken;
        is_last && byte_op && skip;
    endsequence
    chk_skip_flush: assert property (@(posedge mclk) disable iff (reset)
        s_skip_taken |=> executing_nop [*4] ##1 !(st_reg == BOID_FLUSH))
        else $error("skip did not flush one cycle");

    chk_zero_flag: assert property (@(posedge mclk) disable iff (reset)
        (write_q && (fld.op == `BOID_OP_AND || fld.op == `BOID_OP_OR)) |=> flags.z == ($past(res) == 8'h00))
        else $error("zero flag wrong");

    chk_rotate_carry: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_RLC) |=> flags.c == $past(rd_operand_reg[7]) && $stable(flags.z))
        else $error("rotate left carry wrong");

    chk_rotate_right: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_RRC) |=> flags.c == $past(rd_operand_reg[0]) && $stable(flags.dc))
        else $error("rotate right carry wrong");

    chk_zero_acc: assert property (@(posedge mclk) disable iff (reset)
        (zero_acc && q_reg == `BOID_Q_WRITE) |=> acc == 8'h00 && flags.z)
        else $error("accumulator not zeroed");

    chk_read_phase: assert property (@(posedge mclk) disable iff (reset)
        file_rd_stb |-> q_reg == `BOID_Q_READ && uses_file)
        else $error("file read outside read phase");

    sequence s_read_issued;
        q_reg == `BOID_Q_READ && uses_file && file_rd_stb;
    endsequence
    chk_rmw_order: assert property (@(posedge mclk) disable iff (reset)
        s_read_issued |-> ##2 (file_wr_stb == fld.dest))
        else $error("write-back does not follow read");

    chk_unsup_idle: assert property (@(posedge mclk) disable iff (reset)
        unsupported |-> !file_rd_stb && !file_wr_stb)
        else $error("unsupported word touched a file");

    chk_unsup_keeps_state: assert property (@(posedge mclk) disable iff (reset)
        (unsupported && q_reg == `BOID_Q_WRITE) |=> $stable(acc) && $stable(flags))
        else $error("unsupported word changed state");

    chk_flush_quiet: assert property (@(posedge mclk) disable iff (reset)
        (st_reg == BOID_FLUSH) |-> !file_rd_stb && !file_wr_stb && !unsupported)
        else $error("flushed word touched a file");

    chk_flush_keeps_state: assert property (@(posedge mclk) disable iff (reset)
        (st_reg == BOID_FLUSH && is_last) |=> $stable(acc) && $stable(flags))
        else $error("flushed word changed state");

    chk_skip_keeps_flags: assert property (@(posedge mclk) disable iff (reset)
        (write_q && (fld.op == `BOID_OP_DECSKP || fld.op == `BOID_OP_INCSKP)) |=> $stable(flags))
        else $error("skip instruction changed flags");

    chk_dest_acc_write: assert property (@(posedge mclk) disable iff (reset)
        (write_q && !fld.dest && !zero_acc) |=> acc == $past(res))
        else $error("result not placed in accumulator");

    chk_dest_file_keeps: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.dest) |=> $stable(acc))
        else $error("accumulator changed on file destination");

    chk_dec_result: assert property (@(posedge mclk) disable iff (reset)
        (file_wr_stb && fld.op == `BOID_OP_DECSKP) |-> file_wr_data == rd_operand_reg - 8'h01)
        else $error("decrement result wrong");

    chk_inc_result: assert property (@(posedge mclk) disable iff (reset)
        (file_wr_stb && fld.op == `BOID_OP_INCSKP) |-> file_wr_data == rd_operand_reg + 8'h01)
        else $error("increment result wrong");

    chk_nop_quiet: assert property (@(posedge mclk) disable iff (reset)
        (executing_nop && q_reg == `BOID_Q_WRITE) |=> $stable(acc) && $stable(flags))
        else $error("no-op changed state");

    chk_zero_file_flag: assert property (@(posedge mclk) disable iff (reset)
        (file_wr_stb && fld.op == `BOID_OP_ZERO) |=> flags.z)
        else $error("zero-file left zero flag clear");

    chk_and_result: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_AND && !fld.dest) |=> acc == ($past(acc) & $past(rd_operand_reg)))
        else $error("and result wrong");

    chk_or_result: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_OR && !fld.dest) |=> acc == ($past(acc) | $past(rd_operand_reg)))
        else $error("or result wrong");

    chk_add_result: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_ADD && !fld.dest) |=> acc == 8'($past(acc) + $past(rd_operand_reg)))
        else $error("add result wrong");

    chk_add_carry: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_ADD) |=> flags.c == $past(sum[8]) && flags.dc == $past(nib[`BOID_NIB]))
        else $error("add carries wrong");

    chk_rotate_left_data: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_RLC && !fld.dest) |=> acc == {$past(rd_operand_reg[6:0]), $past(flags.c)})
        else $error("rotate left data wrong");

    chk_rotate_right_data: assert property (@(posedge mclk) disable iff (reset)
        (write_q && fld.op == `BOID_OP_RRC && !fld.dest) |=> acc == {$past(flags.c), $past(rd_operand_reg[7:1])})
        else $error("rotate right data wrong");

    chk_literal_width: assert property (@(posedge mclk) disable iff (reset)
        (fld.cls != `BOID_CLASS_CTL) |-> literal[10:8] == 3'h0)
        else $error("short literal not zero extended");
endmodule

// File: test/boid_prog_model.sv
`timescale 1ns/1ps
module boid_prog_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic fetch_stb,
    input wire logic [6:0] file_addr,
    input wire logic file_rd_stb,
    input wire logic file_wr_stb,
    input wire logic [7:0] file_wr_data,
    output logic [13:0] instr_word,
    output logic [7:0] file_rd_data
);
    logic [13:0] prog [0:31];
    logic [7:0] fmem [0:127];
    logic [4:0] pc_reg;
    logic rd_hold_reg;
    // word valid only at the fetch edge, scrambled between fetches
    assign instr_word = fetch_stb ? prog[pc_reg] : ~prog[pc_reg];
    // read data valid in the strobe cycle and the one after
    assign file_rd_data = (file_rd_stb | rd_hold_reg) ? fmem[file_addr] : ~fmem[file_addr];
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pc_reg <= 5'h00;
            rd_hold_reg <= 1'b0;
        end else begin
            rd_hold_reg <= file_rd_stb;
            if (fetch_stb) begin
                pc_reg <= pc_reg + 5'h01;
            end
        end
    end
    always @(posedge mclk) begin
        if (file_wr_stb) begin
            fmem[file_addr] <= file_wr_data;
        end
    end
endmodule

// File: test/boid_decoder_tb_top.sv
`timescale 1ns/1ps
module boid_decoder_tb_top;
    import boid_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [13:0] instr_word;
    logic fetch_stb, file_rd_stb, file_wr_stb, executing_nop, unsupported;
    logic [6:0] file_addr;
    logic [7:0] file_rd_data, file_wr_data, acc;
    logic [2:0] bit_sel;
    logic [10:0] literal;
    boid_flags_t flags;
    int n_errors = 0;
    int samples_checked = 0;
    int rd_cnt = 0, wr_cnt = 0, rd_seen = 0, wr_seen = 0, gap = 0;
    logic [13:0] words [0:15] = '{14'h017F, 14'h0060, 14'h0410, 14'h0710, 14'h0792, 14'h0513, 14'h0D7F,
        14'h0CFF, 14'h0B91, 14'h0710, 14'h0F12, 14'h0193, 14'h0810, 14'h0F94, 14'h0100, 14'h2ABC};
    logic [7:0] exp_acc [0:15] = '{8'h00, 8'h00, 8'h0F, 8'h1E, 8'h1E, 8'h14, 8'h03, 8'h03, 8'h03, 8'h03,
        8'h1E, 8'h1E, 8'h1E, 8'h1E, 8'h1E, 8'h1E};
    logic [2:0] exp_flg [0:15] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6,
        3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
    logic [1:0] exp_rd [0:15] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1,
        2'h0, 2'h1, 2'h0, 2'h0};
    logic [0:15] exp_wr = 16'h0994;
    logic [0:15] nop_set = 16'h4042;
    logic [0:15] unsup_set = 16'h0009;
    logic [6:0] chk_addr [0:5] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h7F};
    logic [7:0] chk_val [0:5] = '{8'h0F, 8'h00, 8'h1D, 8'h00, 8'h00, 8'hC0};

    always #12.5 mclk = ~mclk;

    boid_decoder dut (.mclk(mclk), .reset(reset), .instr_word(instr_word), .fetch_stb(fetch_stb),
        .file_addr(file_addr), .file_rd_stb(file_rd_stb), .file_rd_data(file_rd_data),
        .file_wr_stb(file_wr_stb), .file_wr_data(file_wr_data), .acc(acc), .flags(flags),
        .bit_sel(bit_sel), .literal(literal), .executing_nop(executing_nop), .unsupported(unsupported));
    boid_prog_model mdl (.mclk(mclk), .reset(reset), .fetch_stb(fetch_stb), .file_addr(file_addr),
        .file_rd_stb(file_rd_stb), .file_wr_stb(file_wr_stb), .file_wr_data(file_wr_data),
        .instr_word(instr_word), .file_rd_data(file_rd_data));

    //////////////////////////////////////////////////////////////////////////
    // strobes counted per instruction, window closes at the next fetch edge
    always @(posedge mclk) begin
        if (fetch_stb) begin
            rd_seen <= rd_cnt + int'(file_rd_stb);
            wr_seen <= wr_cnt + int'(file_wr_stb);
            rd_cnt <= 0;
            wr_cnt <= 0;
        end else begin
            rd_cnt <= rd_cnt + int'(file_rd_stb);
            wr_cnt <= wr_cnt + int'(file_wr_stb);
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_fetch();
        gap = 0;
        @(negedge mclk);
        gap++;
        while (fetch_stb !== 1'b1 && gap < 40) begin
            @(negedge mclk);
            gap++;
        end
        @(posedge mclk);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        mdl.fmem[7'h10] = 8'h0F;
        mdl.fmem[7'h11] = 8'h01;
        mdl.fmem[7'h12] = 8'hFF;
        mdl.fmem[7'h13] = 8'h55;
        mdl.fmem[7'h14] = 8'hFF;
        mdl.fmem[7'h7F] = 8'h81;
        for (int i = 0; i < 32; i++) begin
            mdl.prog[i] = (i < 16) ? words[i] : 14'h0000;
        end
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        for (int k = 0; k <= 16; k++) begin
            wait_fetch();
            if (k > 1) begin
                check("fetch spacing", 16'(gap), 16'h0004);
            end
            if (k > 0) begin
                check("accumulator", 16'(acc), 16'(exp_acc[k-1]));
                check("flags", 16'(flags), 16'(exp_flg[k-1]));
                check("write strobes", 16'(wr_seen), 16'(exp_wr[k-1]));
                if (exp_rd[k-1] != 2'h3) begin
                    check("read strobes", 16'(rd_seen), 16'(exp_rd[k-1]));
                end
            end
            if (k < 16) begin
                check("no-op level", 16'(executing_nop), 16'(nop_set[k]));
                check("unsupported", 16'(unsupported), 16'(unsup_set[k]));
                check("bit select", 16'(bit_sel), 16'(words[k][9:7]));
                check("literal", 16'(literal), (words[k][13:12] == 2'h2) ? 16'(words[k][10:0]) : 16'(words[k][7:0]));
            end
        end
        for (int i = 0; i < 6; i++) begin
            check("file contents", 16'(mdl.fmem[chk_addr[i]]), 16'(chk_val[i]));
        end
        complete_run();
    end

    initial begin
        repeat (2000) @(posedge mclk);
        n_errors++;
        complete_run();
    end
endmodule
